/* rtl/bcdc_bank.sv */
// Purpose: Bank of three-decade up/down counters
// Assumes: Core drives requests on clk; no pins cross domains
// Notes: One request per cycle; answers one cycle later
`timescale 1ns/1ps
`include "bcdc_regs.svh"

module bcdc_bank
   import bcdc_pkg::*;
#(
   parameter int CNT_NUM = 128
)(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire bcdc_req_t req_i,
   output bcdc_rsp_t rsp_o
);

   localparam int IDX_BITS = $clog2(CNT_NUM);

   // ====================================
   // State
   // ten bits hold three decades
   logic [`BCDC_CNT_W-1:0] cnt_q [CNT_NUM];
   logic [`BCDC_CNT_W-1:0] cnt_d [CNT_NUM];
   // Edge memory per counter for set, up and down only, as the core's edge flags
   logic [CNT_NUM-1:0] set_last_q;
   logic [CNT_NUM-1:0] set_last_d;
   logic [CNT_NUM-1:0] up_last_q;
   logic [CNT_NUM-1:0] up_last_d;
   logic [CNT_NUM-1:0] dn_last_q;
   logic [CNT_NUM-1:0] dn_last_d;
   bcdc_rsp_t rsp_q;
   bcdc_rsp_t rsp_d;

   // ====================================
   // Decode
   logic hit;
   logic [IDX_BITS-1:0] idx;
   logic [`BCDC_CNT_W-1:0] cur;
   logic cur_nz;
   logic res_bit;
   logic [`BCDC_CNT_W-1:0] preset_bin;
   logic [`BCDC_BCD_W-1:0] cur_bcd;

   function automatic logic rising(input logic now, input logic last);
      rising = now & ~last;
   endfunction

   assign hit = clk_en & req_i.op_valid & ({25'h0, req_i.idx} < CNT_NUM);
   assign idx = req_i.idx[IDX_BITS-1:0];
   assign cur = cnt_q[idx];
   assign cur_nz = (cur != `BCDC_ZERO_COUNT);
   assign res_bit = req_i.logic_result_bit;

   bcdc_bcd2bin u_bcd2bin (
      .acc_i(req_i.primary_accumulator),
      .bin_o(preset_bin)
   );

   bcdc_bin2bcd u_bin2bcd (
      .bin_i(cur),
      .bcd_o(cur_bcd)
   );

   // ====================================
   // Next values
   always_comb begin
      cnt_d = cnt_q;
      set_last_d = set_last_q;
      up_last_d = up_last_q;
      dn_last_d = dn_last_q;
      rsp_d = rsp_q;
      if (clk_en) begin
         rsp_d.rsp_valid = 1'b0;
      end
      if (hit) begin
         case (req_i.op)
            BCDC_OP_SET: begin
               set_last_d[idx] = res_bit;
               if (rising(res_bit, set_last_q[idx])) begin
                  cnt_d[idx] = preset_bin;
               end
            end
            BCDC_OP_RESET: begin
               if (res_bit) begin
                  cnt_d[idx] = `BCDC_ZERO_COUNT;
               end
            end
            BCDC_OP_UP: begin
               up_last_d[idx] = res_bit;
               if (rising(res_bit, up_last_q[idx]) && cur != `BCDC_MAX_COUNT) begin
                  cnt_d[idx] = cur + `BCDC_ONE_COUNT;
               end
            end
            BCDC_OP_DOWN: begin
               dn_last_d[idx] = res_bit;
               if (rising(res_bit, dn_last_q[idx]) && cur_nz) begin
                  cnt_d[idx] = cur - `BCDC_ONE_COUNT;
               end
            end
            BCDC_OP_SCAN: begin
               rsp_d.rsp_valid = 1'b1;
               rsp_d.counter_nonzero_scan = cur_nz;
            end
            BCDC_OP_LOAD: begin
               rsp_d.rsp_valid = 1'b1;
               rsp_d.primary_accumulator = {6'h00, cur};
            end
            BCDC_OP_LOAD_BCD: begin
               rsp_d.rsp_valid = 1'b1;
               rsp_d.primary_accumulator = {4'h0, cur_bcd};
            end
            default: begin
               rsp_d.rsp_valid = 1'b0;
            end
         endcase
      end
   end

   // ====================================
   // Registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < CNT_NUM; i++) begin
            cnt_q[i] <= `BCDC_ZERO_COUNT;
         end
         set_last_q <= '0;
         up_last_q <= '0;
         dn_last_q <= '0;
         rsp_q <= '0;
      end else begin
         cnt_q <= cnt_d;
         set_last_q <= set_last_d;
         up_last_q <= up_last_d;
         dn_last_q <= dn_last_d;
         rsp_q <= rsp_d;
      end
   end

   assign rsp_o = rsp_q;

   // ====================================
   // Checks
   // range kept
   property p_cnt_range;
      @(posedge clk) disable iff (sys_rst)
      cur <= `BCDC_MAX_COUNT;
   endproperty
   a_cnt_range: assert property (p_cnt_range) else $error("count above top");

   property p_set_edge;
      @(posedge clk) disable iff (sys_rst)
      (hit && req_i.op == BCDC_OP_SET && res_bit && !set_last_q[idx])
      |=> cnt_q[$past(idx)] == $past(preset_bin);
   endproperty
   a_set_edge: assert property (p_set_edge) else $error("preset not taken");

   property p_set_steady;
      @(posedge clk) disable iff (sys_rst)
      (hit && req_i.op == BCDC_OP_SET && set_last_q[idx])
      |=> cnt_q[$past(idx)] == $past(cur);
   endproperty
   a_set_steady: assert property (p_set_steady) else $error("preset without edge");

   property p_preset_top;
      @(posedge clk) disable iff (sys_rst)
      (req_i.primary_accumulator[11:0] == 12'h410) |-> preset_bin == 10'h19a;
   endproperty
   a_preset_top: assert property (p_preset_top) else $error("preset misdecoded");

   property p_reset_zero;
      @(posedge clk) disable iff (sys_rst)
      (hit && req_i.op == BCDC_OP_RESET && res_bit) |=> cnt_q[$past(idx)] == `BCDC_ZERO_COUNT;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("reset not zero");

   property p_up_inc;
      @(posedge clk) disable iff (sys_rst)
      (hit && req_i.op == BCDC_OP_UP && res_bit && !up_last_q[idx] && cur != `BCDC_MAX_COUNT)
      |=> cnt_q[$past(idx)] == $past(cur) + `BCDC_ONE_COUNT;
   endproperty
   a_up_inc: assert property (p_up_inc) else $error("up count wrong");

   property p_up_hold;
      @(posedge clk) disable iff (sys_rst)
      (hit && req_i.op == BCDC_OP_UP && !res_bit) |=> cnt_q[$past(idx)] == $past(cur) && !up_last_q[$past(idx)];
   endproperty
   a_up_hold: assert property (p_up_hold) else $error("up moved at zero level");

   property p_dn_dec;
      @(posedge clk) disable iff (sys_rst)
      (hit && req_i.op == BCDC_OP_DOWN && res_bit && !dn_last_q[idx] && cur_nz)
      |=> cnt_q[$past(idx)] == $past(cur) - `BCDC_ONE_COUNT;
   endproperty
   a_dn_dec: assert property (p_dn_dec) else $error("down count wrong");

   property p_saturate;
      @(posedge clk) disable iff (sys_rst)
      (hit && ((req_i.op == BCDC_OP_UP && cur == `BCDC_MAX_COUNT) || (req_i.op == BCDC_OP_DOWN && !cur_nz)))
      |=> cnt_q[$past(idx)] == $past(cur);
   endproperty
   a_saturate: assert property (p_saturate) else $error("count wrapped");

   property p_scan;
      @(posedge clk) disable iff (sys_rst)
      (hit && req_i.op == BCDC_OP_SCAN) |=> rsp_o.rsp_valid && rsp_o.counter_nonzero_scan == $past(cur_nz);
   endproperty
   a_scan: assert property (p_scan) else $error("scan answer wrong");

   property p_load_bin;
      @(posedge clk) disable iff (sys_rst)
      (hit && req_i.op == BCDC_OP_LOAD)
      |=> rsp_o.rsp_valid && rsp_o.primary_accumulator == {6'h00, $past(cur)};
   endproperty
   a_load_bin: assert property (p_load_bin) else $error("binary load wrong");

   property p_load_bcd;
      @(posedge clk) disable iff (sys_rst)
      (hit && req_i.op == BCDC_OP_LOAD_BCD)
      |=> rsp_o.rsp_valid && rsp_o.primary_accumulator[15:12] == 4'h0
          && rsp_o.primary_accumulator[3:0] <= `BCDC_DIGIT_MAX
          && rsp_o.primary_accumulator[7:4] <= `BCDC_DIGIT_MAX;
   endproperty
   a_load_bcd: assert property (p_load_bcd) else $error("BCD load wrong");

   property p_load_bcd_val;
      @(posedge clk) disable iff (sys_rst)
      (hit && req_i.op == BCDC_OP_LOAD_BCD)
      |=> {7'h00, rsp_o.primary_accumulator[`BCDC_D2_LSB +: 4]} * `BCDC_HUNDRED
          + {7'h00, rsp_o.primary_accumulator[`BCDC_D1_LSB +: 4]} * `BCDC_TEN
          + {7'h00, rsp_o.primary_accumulator[`BCDC_D0_LSB +: 4]} == {1'b0, $past(cur)};
   endproperty
   a_load_bcd_val: assert property (p_load_bcd_val) else $error("BCD digits wrong");

   property p_dn_hold;
      @(posedge clk) disable iff (sys_rst)
      (hit && req_i.op == BCDC_OP_DOWN && !res_bit)
      |=> cnt_q[$past(idx)] == $past(cur) && !dn_last_q[$past(idx)];
   endproperty
   a_dn_hold: assert property (p_dn_hold) else $error("down moved at zero level");

   property p_set_low;
      @(posedge clk) disable iff (sys_rst)
      (hit && req_i.op == BCDC_OP_SET && !res_bit)
      |=> cnt_q[$past(idx)] == $past(cur) && !set_last_q[$past(idx)];
   endproperty
   a_set_low: assert property (p_set_low) else $error("preset at zero level");

   property p_reset_idle;
      @(posedge clk) disable iff (sys_rst)
      (hit && req_i.op == BCDC_OP_RESET && !res_bit) |=> cnt_q[$past(idx)] == $past(cur);
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("reset acted at zero level");

   property p_refused;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && req_i.op_valid && req_i.idx >= CNT_NUM) |=> !rsp_o.rsp_valid;
   endproperty
   a_refused: assert property (p_refused) else $error("answer for missing counter");

   property p_rsp_pulse;
      @(posedge clk) disable iff (sys_rst)
      (rsp_o.rsp_valid && $past(clk_en) && !(hit && req_i.op inside {BCDC_OP_SCAN, BCDC_OP_LOAD, BCDC_OP_LOAD_BCD}))
      ##0 clk_en |=> !rsp_o.rsp_valid;
   endproperty
   a_rsp_pulse: assert property (p_rsp_pulse) else $error("answer stuck");

endmodule // bcdc_bank

/* rtl/bcdc_regs.svh */
// Purpose: Constants for the decimal counter bank
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef BCDC_REGS_SVH
`define BCDC_REGS_SVH

// ====================================
// Widths
`define BCDC_CNT_W 10
`define BCDC_ACC_W 16
`define BCDC_IDX_W 7
`define BCDC_BCD_W 12
`define BCDC_SUM_W 11

// ====================================
// Values
`define BCDC_MAX_COUNT 10'h3e7
`define BCDC_ZERO_COUNT 10'h000
`define BCDC_ONE_COUNT 10'h001
`define BCDC_DIGIT_MAX 4'h9
`define BCDC_HUNDRED 11'h064
`define BCDC_TEN 11'h00a
`define BCDC_ACC_RESET 16'h0000

// ====================================
// Digit fields of the accumulator word
`define BCDC_D0_LSB 0
`define BCDC_D1_LSB 4
`define BCDC_D2_LSB 8
`define BCDC_TOP_LSB 12

`endif

/* rtl/bcdc_pkg.sv */
// Purpose: Shared types of the decimal counter bank
// Assumes: bcdc_regs.svh on the include path
// Notes: Types only
`include "bcdc_regs.svh"

package bcdc_pkg;

   // ====================================
   // Operations issued by the execution core
   typedef enum logic [2:0] {
      BCDC_OP_SET = 3'h0,
      BCDC_OP_RESET = 3'h1,
      BCDC_OP_UP = 3'h2,
      BCDC_OP_DOWN = 3'h3,
      BCDC_OP_SCAN = 3'h4,
      BCDC_OP_LOAD = 3'h5,
      BCDC_OP_LOAD_BCD = 3'h6
   } bcdc_op_t;

   // ====================================
   // Request and answer carriers
   typedef struct packed {
      logic op_valid;
      bcdc_op_t op;
      logic [`BCDC_IDX_W-1:0] idx;
      logic logic_result_bit;
      logic [`BCDC_ACC_W-1:0] primary_accumulator;
   } bcdc_req_t;

   typedef struct packed {
      logic rsp_valid;
      logic counter_nonzero_scan;
      logic [`BCDC_ACC_W-1:0] primary_accumulator;
   } bcdc_rsp_t;

endpackage

/* rtl/bcdc_bcd2bin.sv */
// Purpose: Accumulator BCD word to binary count
// Assumes: Digits above nine are the core's fault
// Notes: Combinational; result clamps at the top count
`timescale 1ns/1ps
`include "bcdc_regs.svh"

module bcdc_bcd2bin
   import bcdc_pkg::*;
(
   input wire logic [`BCDC_ACC_W-1:0] acc_i,
   output logic [`BCDC_CNT_W-1:0] bin_o
);

   // ====================================
   // Digit pick
   function automatic logic [`BCDC_SUM_W-1:0] digit(input logic [`BCDC_ACC_W-1:0] w, input int lsb);
      digit = {7'h00, w[lsb +: 4]};
   endfunction

   logic [`BCDC_SUM_W-1:0] sum;

   always_comb begin
      sum = 11'(digit(acc_i, `BCDC_D2_LSB) * `BCDC_HUNDRED)
          + 11'(digit(acc_i, `BCDC_D1_LSB) * `BCDC_TEN)
          + digit(acc_i, `BCDC_D0_LSB);
      // Bad digits can pass the top; clamp keeps the range
      if (sum > {1'b0, `BCDC_MAX_COUNT}) begin
         bin_o = `BCDC_MAX_COUNT;
      end else begin
         bin_o = sum[`BCDC_CNT_W-1:0];
      end
   end

endmodule // bcdc_bcd2bin

/* rtl/bcdc_bin2bcd.sv */
// Purpose: Binary count to three BCD digits
// Assumes: Input never above the top count
// Notes: Combinational
`timescale 1ns/1ps
`include "bcdc_regs.svh"

module bcdc_bin2bcd
   import bcdc_pkg::*;
(
   input wire logic [`BCDC_CNT_W-1:0] bin_i,
   output logic [`BCDC_BCD_W-1:0] bcd_o
);

   // ====================================
   // Digit split
   function automatic logic [3:0] nib(input logic [`BCDC_SUM_W-1:0] v);
      nib = v[3:0];
   endfunction

   logic [`BCDC_SUM_W-1:0] v;

   always_comb begin
      v = {1'b0, bin_i};
      bcd_o = {nib(v / `BCDC_HUNDRED), nib((v / `BCDC_TEN) % `BCDC_TEN), nib(v % `BCDC_TEN)};
   end

endmodule // bcdc_bin2bcd

/* verif/bcdc_core_model.sv */
// Purpose: Execution core stand-in driving counter requests
// Assumes: Requests change only just after a rising clk
// Notes: Idle cycles carry junk behind a low op_valid
`timescale 1ns/1ps

module bcdc_core_model
   import bcdc_pkg::*;
(
   input wire logic clk,
   output bcdc_req_t req
);
   initial req = '0;

   // ====================================
   // Requests
   // accumulator with set
   task automatic issue(input bcdc_op_t op, input logic [6:0] idx, input logic res_bit, input logic [15:0] acc);
      @(posedge clk);
      req <= '{op_valid: 1'b1, op: op, idx: idx, logic_result_bit: res_bit, primary_accumulator: acc};
   endtask

   // Junk on idle, so a held field is never mistaken for a request
   task automatic idle(input logic [31:0] r);
      @(posedge clk);
      req <= bcdc_req_t'({1'b0, r[26:0]});
   endtask

   function automatic logic [15:0] bcd_word(input logic [31:0] r);
      return {r[15:12], 4'(r[11:8] % 10), 4'(r[7:4] % 10), 4'(r[3:0] % 10)};
   endfunction
endmodule // bcdc_core_model

/* verif/tb.sv */
// Purpose: Self-checking bench of the counter bank
// Assumes: Bank built with 16 counters
// Notes: Directed corners, then seeded random traffic
`timescale 1ns/1ps

module tb;
   import bcdc_pkg::*;
   logic clk;
   logic sys_rst;
   logic clk_en;
   bcdc_req_t req;
   bcdc_rsp_t rsp;
   logic [9:0] cnt [16];
   logic mset [16];
   logic mup [16];
   logic mdn [16];
   logic [16:0] exp_q [$];
   logic [31:0] seed = 32'h17;
   logic en_last = 1'b0;
   int miscompares = 0;
   int n_checks = 0;
   int cycles = 0;

   bcdc_bank #(.CNT_NUM(16)) bcdc_bank_inst (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .req_i(req), .rsp_o(rsp));
   bcdc_core_model bcdc_core_model_inst (.clk(clk), .req(req));

   always #5 clk = ~clk;

   // ====================================
   // Helpers
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic finish_test();
      if (miscompares == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ====================================
   // Driver and reference counts
   task automatic run_op(input bcdc_op_t op, input logic [6:0] idx, input logic res_bit, input logic [15:0] acc,
                         input logic en);
      logic [9:0] c;
      int i;
      bcdc_core_model_inst.issue(op, idx, res_bit, acc);
      clk_en <= en;
      if (!en || idx >= 7'h10 || op > BCDC_OP_LOAD_BCD)
         return;
      i = idx;
      c = cnt[i];
      case (op)
         BCDC_OP_SET: begin
            if (res_bit && !mset[i])
               cnt[i] = 10'(acc[11:8] * 100 + acc[7:4] * 10 + acc[3:0]);
            mset[i] = res_bit;
         end
         BCDC_OP_RESET: if (res_bit) cnt[i] = 10'h000;
         BCDC_OP_UP: begin
            if (res_bit && !mup[i] && c != 10'h3e7)
               cnt[i] = c + 10'h001;
            mup[i] = res_bit;
         end
         BCDC_OP_DOWN: begin
            if (res_bit && !mdn[i] && c != 10'h000)
               cnt[i] = c - 10'h001;
            mdn[i] = res_bit;
         end
         BCDC_OP_SCAN: exp_q.push_back({1'b1, 15'h0, c != 10'h000});
         BCDC_OP_LOAD: exp_q.push_back({1'b0, 6'h00, c});
         default: exp_q.push_back({5'h00, 4'(c / 100), 4'((c / 10) % 10), 4'(c % 10)});
      endcase
   endtask

   // ====================================
   // Answer monitor; a held answer under clk_en low is not new
   always @(posedge clk) begin
      logic [16:0] e;
      if (!sys_rst && rsp.rsp_valid === 1'b1 && en_last) begin
         if (exp_q.size() == 0) begin
            check("unexpected answer", 16'h0001, 16'h0000);
         end else begin
            e = exp_q.pop_front();
            if (e[16])
               check("scan result", {15'h0, rsp.counter_nonzero_scan}, e[15:0]);
            else
               check("load result", rsp.primary_accumulator, e[15:0]);
         end
      end
      en_last <= clk_en;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         finish_test();
      end
   end

   // ====================================
   // Main sequence
   initial begin
      logic [31:0] r;
      clk = 1'b0;
      sys_rst = 1'b1;
      clk_en = 1'b1;
      for (int i = 0; i < 16; i++) begin
         cnt[i] = 10'h000;
         mset[i] = 1'b0;
         mup[i] = 1'b0;
         mdn[i] = 1'b0;
      end
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      check("reset acc", rsp.primary_accumulator, 16'h0000);
      for (int i = 0; i < 16; i++)
         run_op(BCDC_OP_SCAN, 7'(i), 1'b0, 16'h0000, 1'b1);
      run_op(BCDC_OP_SET, 7'h03, 1'b1, 16'hf410, 1'b1);
      run_op(BCDC_OP_LOAD, 7'h03, 1'b0, 16'h0000, 1'b1);
      run_op(BCDC_OP_LOAD_BCD, 7'h03, 1'b0, 16'h0000, 1'b1);
      run_op(BCDC_OP_UP, 7'h03, 1'b1, 16'h0000, 1'b1);
      run_op(BCDC_OP_UP, 7'h03, 1'b1, 16'h0000, 1'b1);
      run_op(BCDC_OP_UP, 7'h03, 1'b0, 16'h0000, 1'b1);
      run_op(BCDC_OP_UP, 7'h03, 1'b1, 16'h0000, 1'b1);
      run_op(BCDC_OP_LOAD_BCD, 7'h03, 1'b0, 16'h0000, 1'b1);
      run_op(BCDC_OP_SET, 7'h05, 1'b1, 16'h0999, 1'b1);
      run_op(BCDC_OP_UP, 7'h05, 1'b1, 16'h0000, 1'b1);
      run_op(BCDC_OP_LOAD, 7'h05, 1'b0, 16'h0000, 1'b1);
      run_op(BCDC_OP_DOWN, 7'h06, 1'b1, 16'h0000, 1'b1);
      run_op(BCDC_OP_SCAN, 7'h06, 1'b0, 16'h0000, 1'b1);
      run_op(BCDC_OP_RESET, 7'h03, 1'b1, 16'h0000, 1'b1);
      run_op(BCDC_OP_RESET, 7'h03, 1'b1, 16'h0000, 1'b1);
      run_op(BCDC_OP_SCAN, 7'h03, 1'b0, 16'h0000, 1'b1);
      run_op(BCDC_OP_UP, 7'h10, 1'b1, 16'h0000, 1'b1);
      for (int n = 0; n < 4000; n++) begin
         r = xs();
         run_op(bcdc_op_t'(r[2:0]), (r[31:29] == 3'h0) ? r[28:22] : {5'h00, r[4:3]}, r[5],
                bcdc_core_model_inst.bcd_word(xs()), r[10:8] != 3'h0);
         if (r[12:11] == 2'h0)
            bcdc_core_model_inst.idle(xs());
      end
      bcdc_core_model_inst.idle(xs());
      clk_en <= 1'b1;
      repeat (4) @(posedge clk);
      check("pending answers", 16'(exp_q.size()), 16'h0000);
      finish_test();
   end
endmodule // tb
